// ===== dcic_defines.vh
// Constants for the command input front end
`ifndef DCIC_DEFINES_VH
`define DCIC_DEFINES_VH

// Power states, one-hot
`define DCIC_ST_ACTIVE 4'h1
`define DCIC_ST_PPD 4'h2
`define DCIC_ST_APD 4'h4
`define DCIC_ST_SREF 4'h8

// Decoded command codes
`define DCIC_CMD_NONE 4'h0
`define DCIC_CMD_ACT 4'h1
`define DCIC_CMD_READ 4'h2
`define DCIC_CMD_WRITE 4'h3
`define DCIC_CMD_PRE 4'h4
`define DCIC_CMD_REF 4'h5
`define DCIC_CMD_MRS 4'h6
`define DCIC_CMD_NOP 4'h7
`define DCIC_CMD_ZQ 4'h8

// Additive latency settings
`define DCIC_AL_ZERO 2'h0
`define DCIC_AL_CL1 2'h1
`define DCIC_AL_CL2 2'h2

// Burst modes
`define DCIC_BL_FIXED8 2'h0
`define DCIC_BL_OTF 2'h1
`define DCIC_BL_FIXED4 2'h2

// Organisation
`define DCIC_NUM_BANKS 8
`define DCIC_BANKS_PER_GROUP 4

// Refresh figures for the controller
`define DCIC_REF_COUNT 8192
`define DCIC_TREFI_NORM_NS 7800
`define DCIC_TREFI_HOT_NS 3900
`define DCIC_CLK_NS 10

`endif

// ===== dcic_bank_tracker.v
// Open-row tracker for the eight banks
`timescale 1ns/100ps
`default_nettype none
`include "dcic_defines.vh"

module dcic_bank_tracker #(
   parameter NUM_BANKS = `DCIC_NUM_BANKS
) (
   // Clock and reset
   input wire clk_i,
   input wire reset_i,
   // Events
   input wire open_i,
   input wire close_one_i,
   input wire close_all_i,
   input wire [2:0] bank_i,
   // State
   output reg [NUM_BANKS-1:0] open_banks_o,
   output wire any_open_o
);

   assign any_open_o = |open_banks_o;

   always @(posedge clk_i) begin
      if (reset_i) begin
         open_banks_o <= {NUM_BANKS{1'b0}};
      end else if (close_all_i) begin
         open_banks_o <= {NUM_BANKS{1'b0}};
      end else if (open_i) begin
         open_banks_o[bank_i] <= 1'b1;
      end else if (close_one_i) begin
         open_banks_o[bank_i] <= 1'b0;
      end
   end

endmodule // dcic_bank_tracker

`default_nettype wire

// ===== dcic_front_end.v
// Command and control input front end of the DRAM device
// Summary of operation
// RL1: All pins sampled on rising clock edge
// RL2: Clock gate high runs clocks and buffers
// RL3: Gate low enters precharge/active power-down or refresh
// RL4: Self-refresh exit on gate rise, no clock; here exit waits for the next clock edge
// RL5: Controller keeps gate high during accesses
// RL6: Power-down keeps clock, termination, gate buffers
// RL7: Self-refresh keeps only gate buffer
// RL8: Chip select high masks the command
// RL9: Chip select is part of command code
// RL10: Termination enable applies nominal termination to all
// RL11: Termination ignored when mode register disables
// RL12: Activate reads dual pins as row 16..14
// RL13: Eight banks in two groups of four
// RL14: Controller refreshes 8192 per 64/32 ms
// RL15: Added latency only 0, CL-1, CL-2
// RL16: Burst of eight, chopped four, on the fly
// RL17: Sequential or interleaved burst ordering
// RL18: Strobe high: dual pins are command bits
// RL19: Bank group and bank select target bank
// RL20: Auto-close bit: auto precharge or all banks
// RL21: Burst-chop bit low chops to four
`timescale 1ns/100ps
`default_nettype none
`include "dcic_defines.vh"

module dcic_front_end #(
   parameter NUM_BANKS = `DCIC_NUM_BANKS,
   parameter ROW_BITS = 17
) (
   // Clock and reset
   input wire clk_i,
   input wire reset_i,
   // Command pins
   input wire clock_gate_i,
   input wire chip_select_n_i,
   input wire row_open_strobe_n_i,
   input wire row_strobe_or_addr_bit16_i,
   input wire column_strobe_or_addr_bit15_i,
   input wire write_strobe_or_addr_bit14_i,
   input wire bank_group_select_i,
   input wire [1:0] bank_select_i,
   input wire [13:0] addr_i,
   input wire termination_enable_in_i,
   // Configuration
   input wire nominal_termination_i,
   input wire [1:0] added_latency_i,
   input wire [1:0] burst_mode_i,
   input wire interleaved_i,
   input wire self_refresh_req_i,
   // Decoded command
   output reg cmd_valid_o,
   output reg [3:0] cmd_o,
   output reg [2:0] cmd_bank_o,
   output reg [ROW_BITS-1:0] cmd_row_o,
   output reg [9:0] cmd_col_o,
   output reg cmd_auto_close_o,
   output reg cmd_close_all_o,
   output reg cmd_chopped_o,
   output reg cmd_interleaved_o,
   output reg [1:0] mr_select_o,
   // Status
   output reg [3:0] power_state_o,
   output reg clocks_run_o,
   output reg cmd_buffers_on_o,
   output reg clk_buffers_on_o,
   output reg odt_buffer_on_o,
   output reg outputs_on_o,
   output reg termination_on_o,
   output reg added_latency_bad_o,
   output wire [NUM_BANKS-1:0] open_banks_o
);

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   localparam ST_ACTIVE = `DCIC_ST_ACTIVE;
   localparam ST_PPD = `DCIC_ST_PPD;
   localparam ST_APD = `DCIC_ST_APD;
   localparam ST_SREF = `DCIC_ST_SREF;

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [3:0] dec_cmd;
   wire any_open;
   wire [2:0] bank_addr;
   wire accepting;

   // Bank group is the top bank bit: two groups of four
   assign bank_addr = {bank_group_select_i, bank_select_i}; // RL13 RL19
   // Command buffers are off outside the active state, so no command gets through
   assign accepting = (state_q == ST_ACTIVE) && clock_gate_i; // RL2

   function [3:0] decode_cmd;
      input act_n;
      input ras;
      input cas;
      input we;
      begin
         if (!act_n) begin
            decode_cmd = `DCIC_CMD_ACT; // RL12
         end else begin
            case ({ras, cas, we}) // RL18
               3'h1: decode_cmd = `DCIC_CMD_REF;
               3'h0: decode_cmd = `DCIC_CMD_MRS;
               3'h2: decode_cmd = `DCIC_CMD_PRE;
               3'h5: decode_cmd = `DCIC_CMD_READ;
               3'h4: decode_cmd = `DCIC_CMD_WRITE;
               3'h6: decode_cmd = `DCIC_CMD_ZQ;
               default: decode_cmd = `DCIC_CMD_NOP;
            endcase
         end
      end
   endfunction

   always @* begin
      dec_cmd = `DCIC_CMD_NONE;
      // CS high masks everything; CS low is part of the code
      if (accepting && !chip_select_n_i) begin // RL8 RL9
         dec_cmd = decode_cmd(row_open_strobe_n_i, row_strobe_or_addr_bit16_i,
                              column_strobe_or_addr_bit15_i,
                              write_strobe_or_addr_bit14_i);
      end
   end

   wire is_rdwr = (dec_cmd == `DCIC_CMD_READ) || (dec_cmd == `DCIC_CMD_WRITE);
   wire is_pre = (dec_cmd == `DCIC_CMD_PRE);

   dcic_bank_tracker #(
      .NUM_BANKS(NUM_BANKS)
   ) u_banks (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .open_i(dec_cmd == `DCIC_CMD_ACT),
      .close_one_i((is_pre && !addr_i[10]) || (is_rdwr && addr_i[10])), // RL20
      .close_all_i(is_pre && addr_i[10]), // RL20
      .bank_i(bank_addr),
      .open_banks_o(open_banks_o),
      .any_open_o(any_open)
   );

   // ---------------------------------------------------------------
   // Command output registers
   // ---------------------------------------------------------------
   // All pins captured on the one rising edge
   always @(posedge clk_i) begin // RL1
      if (reset_i) begin
         cmd_valid_o <= 1'b0;
         cmd_o <= `DCIC_CMD_NONE;
         cmd_bank_o <= 3'h0;
         cmd_row_o <= {ROW_BITS{1'b0}};
         cmd_col_o <= 10'h000;
         cmd_auto_close_o <= 1'b0;
         cmd_close_all_o <= 1'b0;
         cmd_chopped_o <= 1'b0;
         cmd_interleaved_o <= 1'b0;
         mr_select_o <= 2'h0;
      end else begin
         cmd_valid_o <= (dec_cmd != `DCIC_CMD_NONE);
         cmd_o <= dec_cmd;
         cmd_bank_o <= bank_addr; // RL19
         cmd_row_o <= {row_strobe_or_addr_bit16_i, column_strobe_or_addr_bit15_i,
                       write_strobe_or_addr_bit14_i, addr_i}; // RL12
         cmd_col_o <= addr_i[9:0];
         cmd_auto_close_o <= is_rdwr && addr_i[10]; // RL20
         cmd_close_all_o <= is_pre && addr_i[10]; // RL20
         // Fixed four, fixed eight, or chop bit chooses per access
         if (burst_mode_i == `DCIC_BL_OTF) begin
            cmd_chopped_o <= is_rdwr && !addr_i[12]; // RL16 RL21
         end else begin
            cmd_chopped_o <= is_rdwr && (burst_mode_i == `DCIC_BL_FIXED4); // RL16
         end
         cmd_interleaved_o <= interleaved_i; // RL17
         if (dec_cmd == `DCIC_CMD_MRS) begin
            mr_select_o <= bank_select_i; // RL19
         end
      end
   end

   // ---------------------------------------------------------------
   // Power state machine
   // ---------------------------------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_ACTIVE: begin
            if (!clock_gate_i) begin
               // Open rows decide which power-down is entered
               if (any_open) begin // RL3
                  state_d = ST_APD;
               end else if (self_refresh_req_i) begin
                  state_d = ST_SREF; // RL3
               end else begin
                  state_d = ST_PPD; // RL3
               end
            end
         end
         ST_PPD, ST_APD: begin
            if (clock_gate_i) begin
               state_d = ST_ACTIVE; // RL2
            end
         end
         ST_SREF: begin
            if (clock_gate_i) begin
               state_d = ST_ACTIVE; // RL4
            end
         end
         default: state_d = ST_ACTIVE;
      endcase
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= ST_ACTIVE;
      end else begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // Buffer and termination controls
   // ---------------------------------------------------------------
   // The gate buffer is never switched off, so exit from self-refresh
   // is taken at the next clock edge; the real pad path is combinational.
   always @(posedge clk_i) begin
      if (reset_i) begin
         power_state_o <= ST_ACTIVE;
         clocks_run_o <= 1'b1;
         cmd_buffers_on_o <= 1'b1;
         clk_buffers_on_o <= 1'b1;
         odt_buffer_on_o <= 1'b1;
         outputs_on_o <= 1'b1;
         termination_on_o <= 1'b0;
         added_latency_bad_o <= 1'b0;
      end else begin
         power_state_o <= state_d;
         clocks_run_o <= (state_d == ST_ACTIVE); // RL2
         outputs_on_o <= (state_d == ST_ACTIVE); // RL2
         cmd_buffers_on_o <= (state_d == ST_ACTIVE); // RL6 RL7
         clk_buffers_on_o <= (state_d != ST_SREF); // RL6 RL7
         odt_buffer_on_o <= (state_d != ST_SREF); // RL6 RL7
         termination_on_o <= termination_enable_in_i && nominal_termination_i
                             && (state_q != ST_SREF); // RL10 RL11
         added_latency_bad_o <= (added_latency_i != `DCIC_AL_ZERO) &&
                                (added_latency_i != `DCIC_AL_CL1) &&
                                (added_latency_i != `DCIC_AL_CL2); // RL15
      end
   end

endmodule // dcic_front_end

`default_nettype wire

// ===== dcic_front_end_sva.sv
// Port-level assertions for the command front end
`timescale 1ns/100ps
`default_nettype none
`include "dcic_defines.vh"
module dcic_chk #(
   parameter NUM_BANKS = `DCIC_NUM_BANKS,
   parameter ROW_BITS = 17
) (
   // Clock, reset and pins
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clock_gate_i,
   input wire logic chip_select_n_i,
   input wire logic row_open_strobe_n_i,
   input wire logic row_strobe_or_addr_bit16_i,
   input wire logic column_strobe_or_addr_bit15_i,
   input wire logic write_strobe_or_addr_bit14_i,
   input wire logic bank_group_select_i,
   input wire logic [1:0] bank_select_i,
   input wire logic [13:0] addr_i,
   input wire logic [1:0] added_latency_i,
   // Outputs
   input wire logic cmd_valid_o,
   input wire logic [3:0] cmd_o,
   input wire logic [2:0] cmd_bank_o,
   input wire logic [ROW_BITS-1:0] cmd_row_o,
   input wire logic [3:0] power_state_o,
   input wire logic cmd_buffers_on_o,
   input wire logic clk_buffers_on_o,
   input wire logic odt_buffer_on_o,
   input wire logic added_latency_bad_o,
   input wire logic [NUM_BANKS-1:0] open_banks_o
);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   wire logic tk = power_state_o == `DCIC_ST_ACTIVE && clock_gate_i && !chip_select_n_i;
   wire logic [2:0] cb = {row_strobe_or_addr_bit16_i, column_strobe_or_addr_bit15_i,
      write_strobe_or_addr_bit14_i};
   cs_mask_a: assert property (chip_select_n_i |=> !cmd_valid_o)
      else $error("masked command decoded");
   act_row_a: assert property (tk && !row_open_strobe_n_i |=> cmd_valid_o
      && cmd_o == `DCIC_CMD_ACT && cmd_row_o == {$past(cb), $past(addr_i)}) else $error("bad act");
   rd_code_a: assert property (tk && row_open_strobe_n_i && cb == 3'h5 |=> cmd_o == 4'h2)
      else $error("bad read decode");
   bank_sel_a: assert property (tk |=>
      cmd_bank_o == $past({bank_group_select_i, bank_select_i})) else $error("bad bank");
   gate_low_a: assert property (!clock_gate_i |=> !cmd_valid_o) else $error("gated cmd");
   act_pd_a: assert property (power_state_o == `DCIC_ST_ACTIVE
      && !clock_gate_i && |open_banks_o |=> power_state_o == `DCIC_ST_APD)
      else $error("no active pd");
   pd_buf_a: assert property (power_state_o == `DCIC_ST_PPD
      || power_state_o == `DCIC_ST_APD |-> clk_buffers_on_o && odt_buffer_on_o
      && !cmd_buffers_on_o) else $error("pd buffers");
   sr_buf_a: assert property (power_state_o == `DCIC_ST_SREF
      |-> !(clk_buffers_on_o || odt_buffer_on_o || cmd_buffers_on_o)) else $error("sr buffers");
   al_bad_a: assert property (added_latency_i == 2'h3 |=> added_latency_bad_o)
      else $error("al");
endmodule // dcic_chk
bind dcic_front_end dcic_chk #(
   .NUM_BANKS(NUM_BANKS),
   .ROW_BITS(ROW_BITS)
) u_chk (
   .clk_i(clk_i),
   .reset_i(reset_i),
   .clock_gate_i(clock_gate_i),
   .chip_select_n_i(chip_select_n_i),
   .row_open_strobe_n_i(row_open_strobe_n_i),
   .row_strobe_or_addr_bit16_i(row_strobe_or_addr_bit16_i),
   .column_strobe_or_addr_bit15_i(column_strobe_or_addr_bit15_i),
   .write_strobe_or_addr_bit14_i(write_strobe_or_addr_bit14_i),
   .bank_group_select_i(bank_group_select_i),
   .bank_select_i(bank_select_i),
   .addr_i(addr_i),
   .added_latency_i(added_latency_i),
   .cmd_valid_o(cmd_valid_o),
   .cmd_o(cmd_o),
   .cmd_bank_o(cmd_bank_o),
   .cmd_row_o(cmd_row_o),
   .power_state_o(power_state_o),
   .cmd_buffers_on_o(cmd_buffers_on_o),
   .clk_buffers_on_o(clk_buffers_on_o),
   .odt_buffer_on_o(odt_buffer_on_o),
   .added_latency_bad_o(added_latency_bad_o),
   .open_banks_o(open_banks_o)
);
`default_nettype wire

// ===== dcic_ctrl.sv
// Controller model that drives the command pins
`timescale 1ns/100ps
`default_nettype none
`include "dcic_defines.vh"
module dcic_ctrl (
   // Request
   input wire logic go_i,
   input wire logic [3:0] code_i,
   input wire logic [16:0] row_i,
   // Pins
   output logic cs_n_o,
   output logic act_n_o,
   output logic [2:0] bits_o,
   output logic [13:0] addr_o
);
   // ---------------------------------------------
   // Pin encoding
   // ---------------------------------------------
   // Pins move just after an edge and hold a full cycle, so the crossing sees them settled
   assign cs_n_o = !go_i;
   assign act_n_o = code_i != `DCIC_CMD_ACT;
   assign addr_o = row_i[13:0];
   always_comb begin
      case (code_i)
         `DCIC_CMD_ACT: bits_o = row_i[16:14];
         `DCIC_CMD_REF: bits_o = 3'h1;
         `DCIC_CMD_MRS: bits_o = 3'h0;
         `DCIC_CMD_PRE: bits_o = 3'h2;
         `DCIC_CMD_READ: bits_o = 3'h5;
         `DCIC_CMD_WRITE: bits_o = 3'h4;
         `DCIC_CMD_ZQ: bits_o = 3'h6;
         default: bits_o = 3'h7;
      endcase
   end
endmodule // dcic_ctrl
`default_nettype wire

// ===== dcic_front_end_tb.sv
// Self-checking bench for the command front end
`timescale 1ns/100ps
`default_nettype none
module dcic_front_end_tb;
   // ---------------------------------------------
   // Signals, model and checks
   // ---------------------------------------------
   logic clk_i = 0, reset_i = 1, gate = 1, go = 0, grp = 0, term = 0, nom = 1, il = 0, sreq = 0;
   logic [1:0] bsel = 0, al = 0, bm = 1;
   logic [3:0] code = 7;
   logic [16:0] row = 0;
   wire logic cs_n, act_n, v, ac, ca, ch, ci, tmo, alb;
   wire logic [2:0] bits, b;
   wire logic [13:0] addr;
   wire logic [3:0] c, ps;
   wire logic [16:0] r;
   wire logic [7:0] obo;
   wire logic [9:0] col;
   wire logic [1:0] mrs;
   wire logic crun, oon, cbon, kbon, obon;
   int failures = 0, samples_checked = 0, cyc = 0;
   int st, ob, ea, ev, ec, eb, er, eac, ech, et, eal, eil, ecol, emr;
   dcic_ctrl u_ctrl (.go_i(go), .code_i(code), .row_i(row), .cs_n_o(cs_n), .act_n_o(act_n),
      .bits_o(bits), .addr_o(addr));
   dcic_front_end DUT (.clk_i(clk_i), .reset_i(reset_i), .clock_gate_i(gate),
      .chip_select_n_i(cs_n), .row_open_strobe_n_i(act_n),
      .row_strobe_or_addr_bit16_i(bits[2]), .column_strobe_or_addr_bit15_i(bits[1]),
      .write_strobe_or_addr_bit14_i(bits[0]), .bank_group_select_i(grp),
      .bank_select_i(bsel), .addr_i(addr), .termination_enable_in_i(term),
      .nominal_termination_i(nom), .added_latency_i(al), .burst_mode_i(bm),
      .interleaved_i(il), .self_refresh_req_i(sreq), .cmd_valid_o(v), .cmd_o(c),
      .cmd_bank_o(b), .cmd_row_o(r), .cmd_col_o(col), .cmd_auto_close_o(ac),
      .cmd_close_all_o(ca), .cmd_chopped_o(ch), .cmd_interleaved_o(ci), .mr_select_o(mrs),
      .power_state_o(ps), .clocks_run_o(crun), .cmd_buffers_on_o(cbon),
      .clk_buffers_on_o(kbon), .odt_buffer_on_o(obon), .outputs_on_o(oon),
      .termination_on_o(tmo), .added_latency_bad_o(alb), .open_banks_o(obo));
   always #5 clk_i = ~clk_i;
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task report_and_stop;
      $display("compares %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Model reads the values sampled at this edge; banks open at the same edge as the decode
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 1000) begin
         failures++;
         report_and_stop;
      end else if (reset_i) begin
         st = 1;
         ob = 0;
         ev = 0;
         ea = 0;
         et = 0;
         eal = 0;
         emr = 0;
      end else begin
         ea = st == 1;
         ev = ea && gate && !cs_n;
         ec = code;
         eb = {grp, bsel};
         er = row;
         eac = addr[10];
         eil = il;
         ecol = addr[9:0];
         ech = bm == 2 ? 1 : bm == 1 ? !addr[12] : 0;
         et = term && nom && st != 8;
         eal = al == 3;
         if (ev && ec == 6) emr = bsel;
         // Power-down choice sees only rows opened before this edge
         if (st == 1 && !gate) st = ob ? 4 : sreq ? 8 : 2;
         else if (gate) st = 1;
         if (ev && ec == 1) ob |= 1 << eb;
         if (ev && (ec == 2 || ec == 3) && eac) ob &= ~(1 << eb);
         if (ev && ec == 4) ob = eac ? 0 : ob & ~(1 << eb);
      end
   end
   always @(negedge clk_i) begin
      if (!reset_i) begin
         chk(v, ev);
         if (ev) chk(c, ec);
         if (ev) chk(b, eb);
         if (ev && ec == 1) chk(r, er);
         if (ev && (ec == 2 || ec == 3)) chk(ch, ech);
         if (ev && (ec == 2 || ec == 3)) chk(ac, eac);
         if (ev && (ec == 2 || ec == 3)) chk(ci, eil);
         if (ev && (ec == 2 || ec == 3)) chk(col, ecol);
         if (ev && ec == 4) chk(ca, eac);
         chk(mrs, emr);
         chk(ps, st);
         chk(crun, st == 1);
         chk(oon, st == 1);
         chk(cbon, st == 1);
         chk(kbon, st != 8);
         chk(obon, st != 8);
         chk(obo, ob);
         chk(alb, eal);
         chk(tmo, et);
      end
   end
   initial begin
      void'($urandom(32'hDDBC));
      repeat (10) @(posedge clk_i);
      reset_i <= 0;
      repeat (200) begin
         @(posedge clk_i);
         go <= $urandom % 4 != 0;
         // Refresh codes come far more often than the average interval asks
         code <= 4'(1 + $urandom % 8);
         row <= 17'($urandom); grp <= 1'($urandom); bsel <= 2'($urandom);
         term <= 1'($urandom); nom <= 1'($urandom); il <= 1'($urandom);
         al <= 2'($urandom); bm <= 2'($urandom % 3);
      end
      // Close all, then precharge pd, self-refresh, and active pd after an activate
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         go <= 1; code <= i == 2 ? 4'h1 : 4'h4; row <= 17'h00400;
         @(posedge clk_i);
         go <= 0;
         repeat (2) @(posedge clk_i);
         sreq <= i == 1; gate <= 0; go <= 1;
         repeat (4) @(posedge clk_i);
         gate <= 1; go <= 0;
         repeat (3) @(posedge clk_i);
      end
      report_and_stop;
   end
endmodule // dcic_front_end_tb
`default_nettype wire
